// File: hw/tad_pkg.sv
`default_nettype none
package tad_pkg;
   // ==========================================
   // Register byte addresses
   localparam logic [11:0] ADDR_CTRL_A    = 12'h000;
   localparam logic [11:0] ADDR_CTRL_B    = 12'h004;
   localparam logic [11:0] ADDR_REQ_SEL   = 12'h008;
   localparam logic [11:0] ADDR_REQ_VALUE = 12'h00C;
   localparam logic [11:0] ADDR_STYLE     = 12'h010;

   // ==========================================
   // Reset values
   localparam logic [7:0] RST_CTRL_A  = 8'h00;
   localparam logic [7:0] RST_CTRL_B  = 8'h00;
   localparam logic [7:0] RST_REQ_SEL = 8'h00;
   localparam logic [7:0] RST_STYLE   = 8'h00;

   // ==========================================
   // acq_display_ctrl_a fields
   localparam int A_ROW24_PLACEMENT  = 7;
   localparam int A_ROW24_SOURCE     = 6;
   localparam int A_AUTO_BLANK       = 5;
   localparam int A_HEADER_ROLL_INH  = 4;
   localparam int A_STATUS_ROW_ONLY  = 3;
   localparam int A_FORCE_BLANK      = 2;
   localparam int A_VPS_CAPTURE      = 1;
   localparam int A_INVENTORY        = 0;

   // ==========================================
   // acq_decode_ctrl_b fields
   localparam int B_EXT_PACKET_INH   = 7;
   localparam int B_RAW_BYTE         = 6;
   localparam int B_ACQ_INH          = 5;
   localparam int B_PACKET26_INH     = 4;
   localparam int B_WHOLE_FIELD      = 3;
   localparam int B_FIELD_POLARITY   = 2;
   localparam int B_LINE_SYNC_POL    = 1;
   localparam int B_FIELD_SYNC_POL   = 0;

   // ==========================================
   // page_request_select and value fields
   localparam int SEL_PAGE_LSB       = 3;
   localparam int SEL_PAGE_W         = 4;
   localparam int SEL_COL_LSB        = 0;
   localparam int SEL_COL_W          = 3;
   localparam int REQ_WORD_W         = 5;

   // ==========================================
   // display_style_ctrl fields
   localparam int S_BANK_SWITCH      = 7;
   localparam int S_QUAD_WIDTH       = 6;
   localparam int S_LANG_EAST        = 5;
   localparam int S_DBL_HEIGHT_INH   = 4;
   localparam int S_BLACK_MESH       = 3;
   localparam int S_COLOUR_MESH      = 2;
   localparam int S_TRANSPARENT      = 1;
   localparam int S_SHADOW           = 0;

   // ==========================================
   // Packet, row and block numbers
   localparam logic [4:0] STATUS_ROW     = 5'h18;
   localparam logic [4:0] PACKET_24      = 5'h18;
   localparam logic [4:0] PACKET_26      = 5'h1A;
   localparam logic [3:0] INVENTORY_BLK  = 4'h8;

   // ==========================================
   // Timing
   localparam int CLK_PERIOD_NS  = 10;
   localparam int LINE_TIME_NS   = 64000;
   localparam int LINE_CYCLES    = LINE_TIME_NS / CLK_PERIOD_NS;
   localparam int VBI_FIRST_LINE = 7;
   localparam int VBI_LAST_LINE  = 22;
endpackage
`default_nettype wire

// File: hw/tad_ctrl.sv
// Behaviour
// - Placement bit 0 stores packet 24 in extension memory, 1 in page memory
// - Source bit 0 shows row-24 data from page memory, 1 from extension memory
// - Auto blanking drops overlay output on video; forcing bit holds it low
// - Header-roll inhibit blocks writing rolling headers and time into memory
// - Status-row-only shows memory row 24 and suppresses all other rows
// - VPS capture enable allows VPS data capture; cleared means no capture
// - Inventory capture bit stores the inventory page in memory block 8
// - Extension packet inhibit stops decoding of extension packets
// - Raw byte mode writes packets 0 to 24 without error checking
// - Acquisition inhibit blocks every acquisition write into memory
// - Packet-26 inhibit disables automatic processing of packet 26
// - Whole-field 0 decodes only blanking lines, 1 decodes every line
// - Field polarity gives the line half of field sync at even field start
// - Sync polarity bits select positive (0) or negative (1) going inputs
// - Request word modifies the selected page starting at the start column
// - Bank switch enable allows switching between on-screen character banks
// - Quad width enable allows quadruple width characters
// - Language region 0 selects western, 1 eastern character set
// - Double height inhibit ignores double height codes in on-screen boxes
// - Two mesh bits mesh black background and other colour areas
// - Transparency enable renders black background as transparent video
// - Shadow enable gives characters a south-east shadow
`timescale 1ns/10ps
`default_nettype none
module tad_ctrl #(
   parameter int LINE_CYCLES = tad_pkg::LINE_CYCLES,
   parameter int VBI_FIRST   = tad_pkg::VBI_FIRST_LINE,
   parameter int VBI_LAST    = tad_pkg::VBI_LAST_LINE
) (
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic        clkEn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        hsyncPin,
   input  wire logic        vsyncPin,
   output logic             lineSync,
   output logic             fieldSync,
   output logic             evenField,
   output logic             decodeLine,
   input  wire logic        acqWrReq,
   input  wire logic [4:0]  acqPacket,
   input  wire logic        acqRollHdr,
   input  wire logic        acqVps,
   input  wire logic        acqInventory,
   output logic             memWrEn,
   output logic             memWrExt,
   output logic             memWrInvBlk,
   output logic [3:0]       memWrBlock,
   output logic             bypassCheck,
   output logic             extPacketDecode,
   output logic             packet26Process,
   input  wire logic        videoShown,
   input  wire logic        frameReq,
   input  wire logic [4:0]  dispRow,
   output logic             frameOut,
   output logic             rowVisible,
   output logic             row24FromExt,
   output logic             bankSwitchEn,
   output logic             quadWidthEn,
   output logic             languageEast,
   output logic             dblHeightBoxInh,
   output logic             blackMeshEn,
   output logic             colourMeshEn,
   output logic             transparentBlack,
   output logic             shadowEn,
   output logic             pageReqWr,
   output logic [3:0]       pageReqPage,
   output logic [2:0]       pageReqCol,
   output logic [4:0]       pageReqData
);
   import tad_pkg::*;

   // ==========================================
   // Address decode
   function automatic logic regHit(input logic [11:0] a, input logic [11:0] off);
      regHit = (a[11:2] == off[11:2]);
   endfunction

   logic [7:0] ctrlA;
   logic [7:0] ctrlB;
   logic [7:0] reqSel;
   logic [7:0] style;
   logic       accessPh;
   logic       mapped;
   logic       wrByte;

   assign accessPh = psel & penable;
   assign wrByte   = accessPh & pwrite & pstrb[0];

   always_comb
   begin
      if (regHit(paddr, ADDR_CTRL_A))
         mapped = 1'b1;
      else if (regHit(paddr, ADDR_CTRL_B))
         mapped = 1'b1;
      else if (regHit(paddr, ADDR_REQ_SEL))
         mapped = 1'b1;
      else if (regHit(paddr, ADDR_REQ_VALUE))
         mapped = 1'b1;
      else if (regHit(paddr, ADDR_STYLE))
         mapped = 1'b1;
      else
         mapped = 1'b0;
   end

   // Zero-wait slave; reads of write-only registers give zero
   assign pready  = 1'b1;
   assign pslverr = accessPh & ~mapped;
   assign prdata  = 32'h0000_0000;

   // ==========================================
   // Control registers
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrlA  <= RST_CTRL_A;
         ctrlB  <= RST_CTRL_B;
         reqSel <= RST_REQ_SEL;
         style  <= RST_STYLE;
      end
      else if (clkEn && wrByte)
      begin
         if (regHit(paddr, ADDR_CTRL_A))
            ctrlA <= pwdata[7:0];
         else if (regHit(paddr, ADDR_CTRL_B))
            ctrlB <= pwdata[7:0];
         else if (regHit(paddr, ADDR_REQ_SEL))
            reqSel <= pwdata[7:0];
         else if (regHit(paddr, ADDR_STYLE))
            style <= pwdata[7:0];
      end
   end

   // ==========================================
   // Page request strobe
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pageReqWr   <= 1'b0;
         pageReqPage <= 4'h0;
         pageReqCol  <= 3'h0;
         pageReqData <= 5'h00;
      end
      else if (clkEn)
      begin
         pageReqWr <= wrByte & regHit(paddr, ADDR_REQ_VALUE);
         if (wrByte && regHit(paddr, ADDR_REQ_VALUE))
         begin
            pageReqPage <= reqSel[SEL_PAGE_LSB +: SEL_PAGE_W];
            pageReqCol  <= reqSel[SEL_COL_LSB +: SEL_COL_W];
            pageReqData <= pwdata[REQ_WORD_W-1:0];
         end
      end
   end

   // ==========================================
   // Sync input synchronisers
   logic hsMeta;
   logic hsSync;
   logic vsMeta;
   logic vsSync;

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         hsMeta <= 1'b0;
         hsSync <= 1'b0;
         vsMeta <= 1'b0;
         vsSync <= 1'b0;
      end
      else if (clkEn)
      begin
         hsMeta <= hsyncPin;
         hsSync <= hsMeta;
         vsMeta <= vsyncPin;
         vsSync <= vsMeta;
      end
   end

   // ==========================================
   // Sync polarity and edge detection
   logic hLevel;
   logic vLevel;
   logic hPrev;
   logic vPrev;
   logic hEdge;
   logic vEdge;

   assign hLevel = hsSync ^ ctrlB[B_LINE_SYNC_POL];
   assign vLevel = vsSync ^ ctrlB[B_FIELD_SYNC_POL];
   assign hEdge  = hLevel & ~hPrev;
   assign vEdge  = vLevel & ~vPrev;

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         hPrev     <= 1'b0;
         vPrev     <= 1'b0;
         lineSync  <= 1'b0;
         fieldSync <= 1'b0;
      end
      else if (clkEn)
      begin
         hPrev     <= hLevel;
         vPrev     <= vLevel;
         lineSync  <= hEdge;
         fieldSync <= vEdge;
      end
   end

   // ==========================================
   // Line position and field parity
   logic [15:0] lineCnt;
   logic [9:0]  lineNum;
   logic        secondHalf;

   assign secondHalf = (lineCnt >= 16'(LINE_CYCLES / 2));

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         lineCnt <= 16'h0000;
      else if (clkEn)
      begin
         if (hEdge)
            lineCnt <= 16'h0000;
         else if (lineCnt != 16'hFFFF)
            lineCnt <= lineCnt + 16'h0001;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         lineNum   <= 10'h000;
         evenField <= 1'b0;
      end
      else if (clkEn)
      begin
         if (vEdge)
         begin
            lineNum   <= 10'h000;
            evenField <= (secondHalf == ctrlB[B_FIELD_POLARITY]);
         end
         else if (hEdge && lineNum != 10'h3FF)
            lineNum <= lineNum + 10'h001;
      end
   end

   // ==========================================
   // Decode line gate
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         decodeLine <= 1'b0;
      else if (clkEn)
         decodeLine <= ctrlB[B_WHOLE_FIELD] |
                       ((lineNum >= 10'(VBI_FIRST)) && (lineNum <= 10'(VBI_LAST)));
   end

   // ==========================================
   // Acquisition write gating
   logic wrAllowed;
   logic isPkt24;
   logic upTo24;

   assign isPkt24 = (acqPacket == PACKET_24);
   assign upTo24  = (acqPacket <= PACKET_24);

   always_comb
   begin
      wrAllowed = acqWrReq;
      if (ctrlB[B_ACQ_INH])
         wrAllowed = 1'b0;
      else if (acqRollHdr && ctrlA[A_HEADER_ROLL_INH])
         wrAllowed = 1'b0;
      else if (acqVps && !ctrlA[A_VPS_CAPTURE])
         wrAllowed = 1'b0;
      else if (acqInventory && !ctrlA[A_INVENTORY])
         wrAllowed = 1'b0;
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         memWrEn     <= 1'b0;
         memWrExt    <= 1'b0;
         memWrInvBlk <= 1'b0;
         memWrBlock  <= 4'h0;
         bypassCheck <= 1'b0;
      end
      else if (clkEn)
      begin
         memWrEn     <= wrAllowed;
         memWrExt    <= isPkt24 & ~ctrlA[A_ROW24_PLACEMENT];
         memWrInvBlk <= acqInventory & ctrlA[A_INVENTORY];
         memWrBlock  <= (acqInventory && ctrlA[A_INVENTORY]) ? INVENTORY_BLK : 4'h0;
         bypassCheck <= ctrlB[B_RAW_BYTE] & upTo24;
      end
   end

   // ==========================================
   // Acquisition enables
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         extPacketDecode <= 1'b0;
         packet26Process <= 1'b0;
      end
      else if (clkEn)
      begin
         extPacketDecode <= ~ctrlB[B_EXT_PACKET_INH];
         packet26Process <= ~ctrlB[B_PACKET26_INH] &
                            (acqPacket == PACKET_26);
      end
   end

   // ==========================================
   // Overlay blanking and row selection
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         frameOut     <= 1'b0;
         rowVisible   <= 1'b0;
         row24FromExt <= 1'b0;
      end
      else if (clkEn)
      begin
         if (ctrlA[A_FORCE_BLANK])
            frameOut <= 1'b0;
         else if (ctrlA[A_AUTO_BLANK] && videoShown)
            frameOut <= 1'b0;
         else
            frameOut <= frameReq;
         rowVisible   <= ~ctrlA[A_STATUS_ROW_ONLY] | (dispRow == STATUS_ROW);
         row24FromExt <= ctrlA[A_ROW24_SOURCE];
      end
   end

   // ==========================================
   // Display style
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         bankSwitchEn     <= 1'b0;
         quadWidthEn      <= 1'b0;
         languageEast     <= 1'b0;
         dblHeightBoxInh  <= 1'b0;
         blackMeshEn      <= 1'b0;
         colourMeshEn     <= 1'b0;
         transparentBlack <= 1'b0;
         shadowEn         <= 1'b0;
      end
      else if (clkEn)
      begin
         bankSwitchEn     <= style[S_BANK_SWITCH];
         quadWidthEn      <= style[S_QUAD_WIDTH];
         languageEast     <= style[S_LANG_EAST];
         dblHeightBoxInh  <= style[S_DBL_HEIGHT_INH];
         blackMeshEn      <= style[S_BLACK_MESH];
         colourMeshEn     <= style[S_COLOUR_MESH];
         transparentBlack <= style[S_TRANSPARENT];
         shadowEn         <= style[S_SHADOW];
      end
   end

endmodule // tad_ctrl
`default_nettype wire

// File: dv/tad_ctrl_checker.sv
`timescale 1ns/10ps
`default_nettype none
module tad_ctrl_checker (
   input wire logic        ref_clk,
   input wire logic        nrst,
   input wire logic        clkEn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        acqWrReq,
   input wire logic [4:0]  acqPacket,
   input wire logic        memWrEn,
   input wire logic        memWrExt,
   input wire logic        memWrInvBlk,
   input wire logic [3:0]  memWrBlock,
   input wire logic        bypassCheck,
   input wire logic        packet26Process,
   input wire logic        lineSync,
   input wire logic        pageReqWr,
   input wire logic [4:0]  pageReqData
);
   import tad_pkg::*;
   // ==========================================
   // Properties
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   sequence s_req_access;
      psel && penable && pwrite && paddr == ADDR_REQ_VALUE && pstrb[0] && clkEn;
   endsequence
   sequence s_req_pulse;
      pageReqWr && pageReqData == $past(pwdata[4:0]) ##1 !pageReqWr;
   endsequence

   chk_req_pulse: assert property (s_req_access |=> s_req_pulse)
      else $error("page request pulse wrong");
   chk_read_zero: assert property (prdata == 32'h0000_0000)
      else $error("read data not zero");
   chk_unmapped_err: assert property (psel && penable |-> pslverr == (paddr[11:2] > 10'h004))
      else $error("error response wrong");
   chk_write_cause: assert property (memWrEn && $past(clkEn) |-> $past(acqWrReq))
      else $error("memory write without request");
   chk_ext_packet: assert property (memWrExt && $past(clkEn) |-> $past(acqPacket) == PACKET_24)
      else $error("extension store for wrong packet");
   chk_inv_block: assert property (memWrInvBlk |-> memWrBlock == INVENTORY_BLK)
      else $error("inventory block wrong");
   chk_bypass_range: assert property (bypassCheck && $past(clkEn) |-> $past(acqPacket) <= PACKET_24)
      else $error("bypass outside packet range");
   chk_p26_only: assert property (packet26Process && $past(clkEn) |-> $past(acqPacket) == PACKET_26)
      else $error("packet 26 flag for other packet");
   chk_sync_pulse: assert property (lineSync && clkEn |=> !lineSync)
      else $error("line sync pulse too long");
endmodule // tad_ctrl_checker

bind tad_ctrl tad_ctrl_checker u_chk (.ref_clk(ref_clk), .nrst(nrst), .clkEn(clkEn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
   .pslverr(pslverr), .acqWrReq(acqWrReq), .acqPacket(acqPacket), .memWrEn(memWrEn), .memWrExt(memWrExt),
   .memWrInvBlk(memWrInvBlk), .memWrBlock(memWrBlock), .bypassCheck(bypassCheck),
   .packet26Process(packet26Process), .lineSync(lineSync), .pageReqWr(pageReqWr), .pageReqData(pageReqData));
`default_nettype wire

// File: dv/test_tad_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; $display("ERROR %0t mismatch", $time); end end
module test_tad_ctrl;
   import tad_pkg::*;
   // ==========================================
   // Signals
   logic        ref_clk, nrst, clkEn, psel, penable, pwrite, hsyncPin, vsyncPin, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [3:0]  pstrb, memWrBlock, pageReqPage;
   logic        lineSync, fieldSync, evenField, decodeLine, acqWrReq, acqRollHdr, acqVps, acqInventory;
   logic [4:0]  acqPacket, dispRow, pageReqData;
   logic        memWrEn, memWrExt, memWrInvBlk, bypassCheck, extPacketDecode, packet26Process, rerr;
   logic        videoShown, frameReq, frameOut, rowVisible, row24FromExt, pageReqWr;
   logic [7:0]  style;
   logic [2:0]  pageReqCol;
   int          miscompares, comparisons, cycles, found;

   tad_ctrl #(.LINE_CYCLES(64)) u_dut (.ref_clk(ref_clk), .nrst(nrst), .clkEn(clkEn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .hsyncPin(hsyncPin), .vsyncPin(vsyncPin), .lineSync(lineSync),
      .fieldSync(fieldSync), .evenField(evenField), .decodeLine(decodeLine), .acqWrReq(acqWrReq),
      .acqPacket(acqPacket), .acqRollHdr(acqRollHdr), .acqVps(acqVps), .acqInventory(acqInventory),
      .memWrEn(memWrEn), .memWrExt(memWrExt), .memWrInvBlk(memWrInvBlk), .memWrBlock(memWrBlock),
      .bypassCheck(bypassCheck), .extPacketDecode(extPacketDecode), .packet26Process(packet26Process),
      .videoShown(videoShown), .frameReq(frameReq), .dispRow(dispRow), .frameOut(frameOut),
      .rowVisible(rowVisible), .row24FromExt(row24FromExt), .bankSwitchEn(style[7]), .quadWidthEn(style[6]),
      .languageEast(style[5]), .dblHeightBoxInh(style[4]), .blackMeshEn(style[3]), .colourMeshEn(style[2]),
      .transparentBlack(style[1]), .shadowEn(style[0]), .pageReqWr(pageReqWr), .pageReqPage(pageReqPage),
      .pageReqCol(pageReqCol), .pageReqData(pageReqData));

   // ==========================================
   // Clock, timeout and verdict
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         miscompares++;
         stop_test();
      end
   end

   task stop_test();
      if (miscompares == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ==========================================
   // Access tasks
   task wt(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task rd(input logic [11:0] a, input logic ee);
      xfer(1'b0, a, 32'h0000_0000);
      `CHK(rdat, 32'h0000_0000)
      `CHK(rerr, ee)
   endtask

   task ab(input logic [7:0] a, input logic [7:0] b);
      xfer(1'b1, ADDR_CTRL_A, 32'(a));
      xfer(1'b1, ADDR_CTRL_B, 32'(b));
   endtask

   // Request a write with qualifiers {roll, vps, inventory}
   task acq(input logic [4:0] p, input logic [2:0] q, input logic e);
      @(posedge ref_clk);
      acqWrReq <= 1'b1;
      acqPacket <= p;
      {acqRollHdr, acqVps, acqInventory} <= q;
      wt(1);
      `CHK(memWrEn, e)
   endtask

   task dsp(input logic [4:0] r, input logic v, input logic [1:0] e);
      @(posedge ref_clk);
      dispRow <= r;
      videoShown <= v;
      wt(1);
      `CHK({rowVisible, frameOut}, e)
   endtask

   task sy(input logic v);
      @(posedge ref_clk);
      {hsyncPin, vsyncPin} <= {v, v};
      found = 0;
      repeat (8)
      begin
         wt(1);
         found = found + int'(lineSync === 1'b1) + int'(fieldSync === 1'b1);
      end
      `CHK(found, 2)
   endtask

   // One rising edge on the line sync pin, settled through the synchroniser
   task hp();
      @(posedge ref_clk);
      hsyncPin <= 1'b0;
      wt(3);
      @(posedge ref_clk);
      hsyncPin <= 1'b1;
      wt(3);
   endtask

   // ==========================================
   // Tests
   initial
   begin
      {nrst, psel, penable, pwrite, hsyncPin, vsyncPin, acqWrReq, acqRollHdr, acqVps, acqInventory} = '0;
      {paddr, pwdata, acqPacket, dispRow, videoShown} = '0;
      clkEn = 1'b1;
      frameReq = 1'b1;
      pstrb = 4'h1;
      repeat (8) @(posedge ref_clk);
      nrst <= 1'b1;
      wt(1);
      `CHK({extPacketDecode, style}, 9'h100)
      for (int a = 0; a < 6; a++)
      begin
         rd(12'(a * 4), a == 5);
      end
      xfer(1'b1, ADDR_REQ_SEL, 32'h0000_0055);
      xfer(1'b1, ADDR_REQ_VALUE, 32'h0000_00F3);
      #1;
      `CHK({pageReqWr, pageReqPage, pageReqCol, pageReqData}, {1'b1, 4'hA, 3'h5, 5'h13})
      wt(1);
      `CHK(pageReqWr, 1'b0)
      for (int i = 0; i < 8; i++)
      begin
         xfer(1'b1, ADDR_STYLE, 32'(1) << i);
         wt(1);
         `CHK(style, 8'(1) << i)
      end
      ab(8'h00, 8'h00);
      acq(PACKET_24, 3'b000, 1'b1);
      `CHK({memWrExt, row24FromExt}, 2'b10)
      acq(5'h03, 3'b100, 1'b1);
      acq(5'h03, 3'b010, 1'b0);
      acq(5'h03, 3'b001, 1'b0);
      ab(8'h13, 8'h00);
      acq(5'h03, 3'b100, 1'b0);
      acq(5'h03, 3'b010, 1'b1);
      acq(5'h03, 3'b001, 1'b1);
      `CHK({memWrInvBlk, memWrBlock}, {1'b1, INVENTORY_BLK})
      ab(8'hC0, 8'h00);
      acq(PACKET_24, 3'b000, 1'b1);
      `CHK({memWrExt, row24FromExt}, 2'b01)
      ab(8'h00, 8'h20);
      acq(5'h03, 3'b000, 1'b0);
      ab(8'h00, 8'h40);
      acq(PACKET_24, 3'b000, 1'b1);
      `CHK(bypassCheck, 1'b1)
      acq(5'h19, 3'b000, 1'b1);
      `CHK(bypassCheck, 1'b0)
      ab(8'h00, 8'h80);
      acq(PACKET_26, 3'b000, 1'b1);
      `CHK({extPacketDecode, packet26Process}, 2'b01)
      ab(8'h00, 8'h10);
      acq(PACKET_26, 3'b000, 1'b1);
      `CHK({extPacketDecode, packet26Process}, 2'b10)
      ab(8'h08, 8'h08);
      dsp(5'h05, 1'b1, 2'b01);
      dsp(STATUS_ROW, 1'b1, 2'b11);
      `CHK(decodeLine, 1'b1)
      ab(8'h20, 8'h00);
      dsp(5'h05, 1'b1, 2'b10);
      dsp(5'h05, 1'b0, 2'b11);
      ab(8'h24, 8'h00);
      dsp(5'h05, 1'b0, 2'b10);
      sy(1'b1);
      `CHK(evenField, 1'b0)
      ab(8'h00, 8'h03);
      sy(1'b0);
      // ==========================================
      // Field parity and blanking-line window, positive sync, field polarity 1
      ab(8'h00, 8'h04);
      hp();
      wt(40);
      @(posedge ref_clk);
      vsyncPin <= 1'b1;
      wt(4);
      `CHK(evenField, 1'b1)
      @(posedge ref_clk);
      vsyncPin <= 1'b0;
      hp();
      @(posedge ref_clk);
      vsyncPin <= 1'b1;
      wt(4);
      `CHK({evenField, decodeLine}, 2'b00)
      repeat (6) hp();
      wt(1);
      `CHK(decodeLine, 1'b0)
      hp();
      wt(1);
      `CHK(decodeLine, 1'b1)
      @(posedge ref_clk);
      clkEn <= 1'b0;
      xfer(1'b1, ADDR_STYLE, 32'h0000_00FF);
      clkEn <= 1'b1;
      pstrb <= 4'h0;
      xfer(1'b1, ADDR_STYLE, 32'h0000_00FF);
      pstrb <= 4'h1;
      wt(1);
      `CHK(style, 8'h80)
      stop_test();
   end
endmodule // test_tad_ctrl
`default_nettype wire
